// ---- wdpc_pkg.sv ----
// Purpose: Constants and types for the watchdog plug-and-play configuration port
// Assumes: Host I/O cycles arrive already decoded into address, data and strobe
// Notes:   Register numbers are configuration indices; base offsets are 0 to 7
// Overview of operation
// RL1: Key 46h then 57h enters configuration
// RL2: Key 57h then 46h leaves configuration
// RL3: Index and data ports answer only in configuration
// RL4: Device selector at 7h, resets 01h
// RL5: Counter bytes at 38h-3ah and base+0-2
// RL6: Reload bytes 3bh-3dh, reset 00h 40h 00h
// RL7: Status 3eh read-write, control 3fh resets 03h
// RL8: Base address from 60h and 61h, eight-aligned
// RL9: Bit 0 of 30h activates the device
// RL10: Low nibble of 70h routes timeout event
// RL11: Codes 08h, 0dh-0fh drive no line
// RL12: F1h bit 4 enables port 80h reload
// RL13: F1h bits 3,1 write-hit window enables
// RL14: Window bases at F2h-F5h, reset zero
// RL15: Window masks at F6h, reset FFh
// RL16: Every trigger loads counter with reload value
// RL17: Read hits reload via bits 2 and 0
// RL18: Each window spans 1 to 16 bytes
// RL19: Mask bits release low address bits
// RL20: Broken key discarded, mode kept
package wdpc_pkg;
    localparam logic [15:0] CFG_PORT_ADDR   = 16'h0302;
    localparam logic [15:0] DATA_PORT_ADDR  = 16'h0303;
    localparam logic [15:0] POST_PORT_ADDR  = 16'h0080;
    localparam logic [7:0]  KEY_A           = 8'h46;
    localparam logic [7:0]  KEY_B           = 8'h57;
    localparam logic [7:0]  WDT_DEVICE_NUM  = 8'h01;
    // Configuration indices
    localparam logic [7:0]  IDX_LDN         = 8'h07;
    localparam logic [7:0]  IDX_ACTIVATE    = 8'h30;
    localparam logic [7:0]  IDX_CNT0        = 8'h38;
    localparam logic [7:0]  IDX_CNT1        = 8'h39;
    localparam logic [7:0]  IDX_CNT2        = 8'h3a;
    localparam logic [7:0]  IDX_RLD0        = 8'h3b;
    localparam logic [7:0]  IDX_RLD1        = 8'h3c;
    localparam logic [7:0]  IDX_RLD2        = 8'h3d;
    localparam logic [7:0]  IDX_STATUS      = 8'h3e;
    localparam logic [7:0]  IDX_CONTROL     = 8'h3f;
    localparam logic [7:0]  IDX_BASE_HI     = 8'h60;
    localparam logic [7:0]  IDX_BASE_LO     = 8'h61;
    localparam logic [7:0]  IDX_IRQ         = 8'h70;
    localparam logic [7:0]  IDX_SPARE_F0    = 8'hf0;
    localparam logic [7:0]  IDX_SRC_EN      = 8'hf1;
    localparam logic [7:0]  IDX_W1_LO       = 8'hf2;
    localparam logic [7:0]  IDX_W1_HI       = 8'hf3;
    localparam logic [7:0]  IDX_W2_LO       = 8'hf4;
    localparam logic [7:0]  IDX_W2_HI       = 8'hf5;
    localparam logic [7:0]  IDX_MASKS       = 8'hf6;
    // Reset values
    localparam logic [7:0]  RST_LDN         = 8'h01;
    localparam logic [23:0] RST_RELOAD      = 24'h004000;
    localparam logic [7:0]  RST_STATUS      = 8'h00;
    localparam logic [7:0]  RST_CONTROL     = 8'h03;
    localparam logic [7:0]  RST_MASKS       = 8'hff;
    // Field positions in reload_source_enable
    localparam int          POS_W1_RD       = 0;
    localparam int          POS_W1_WR       = 1;
    localparam int          POS_W2_RD       = 2;
    localparam int          POS_W2_WR       = 3;
    localparam int          POS_POST        = 4;
    localparam logic [3:0]  ROUTE_SMI       = 4'h2;

    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_ENTER, KEY_GOT_EXIT} wdpc_key_t;

    typedef struct packed {
        logic        cfg_mode;
        wdpc_key_t   key;
        logic [7:0]  index;
        logic [7:0]  logical_device_select;
        logic [7:0]  activate;
        logic [23:0] counter;
        logic [23:0] reload;
        logic [7:0]  status;
        logic [7:0]  control;
        logic [7:0]  base_hi;
        logic [7:0]  base_lo;
        logic [7:0]  irq_route;
        logic [7:0]  spare_f0;
        logic [7:0]  src_en;
        logic [15:0] win1_base;
        logic [15:0] win2_base;
        logic [7:0]  masks;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        reload_pulse;
        logic [15:0] irq_lines;
        logic        smi;
    } wdpc_state_t;
endpackage : wdpc_pkg

// ---- wdpc_config_port.sv ----
// Purpose: Plug-and-play configuration front end of the watchdog
// Assumes: One decoded I/O cycle per io_valid pulse, inputs synchronous to clk_sys
// Notes:   The countdown engine is outside; it reports timeouts on timeout_evt
module wdpc_config_port
    import wdpc_pkg::*;
(
    input  wire logic        clk_sys,      // 200 MHz system clock
    input  wire logic        rst_n,        // Synchronous reset, active low
    input  wire logic        clk_en,       // Freezes all state while low
    input  wire logic        io_valid,     // One-cycle I/O cycle strobe
    input  wire logic        io_write,     // 1 write, 0 read
    input  wire logic [15:0] io_addr,      // I/O address
    input  wire logic [7:0]  io_wdata,     // Write data
    input  wire logic        timeout_evt,  // Counter expiry pulse from engine
    output logic      [7:0]  io_rdata,     // Read data, registered
    output logic             io_rvalid,    // Read answered this cycle
    output logic      [23:0] counter_value,// Current counter value
    output logic      [23:0] reload_value, // Programmed reload value
    output logic      [7:0]  timeout_control, // Control byte
    output logic      [7:0]  timeout_status,  // Status byte
    output logic             reload_pulse, // Counter was reloaded
    output logic             device_active,// Logical device switched on
    output logic      [15:0] irq_lines,    // Routed timeout, one per IRQ
    output logic             smi_out       // Routed timeout to SMI
);
    wdpc_state_t s_r;
    wdpc_state_t s_nxt;

    logic        wr;
    logic        rd;
    logic        cfg_hit;
    logic        data_hit;
    logic        base_hit;
    logic        win1_hit;
    logic        win2_hit;
    logic        dev_sel;
    logic        acc_en;
    logic        acc_we;
    logic [7:0]  acc_idx;
    logic [7:0]  acc_rd;
    logic        trigger;

    // Read mux over the indexed registers; unmapped indices read zero
    function automatic logic [7:0] reg_read(input wdpc_state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == IDX_CNT0)          v = s.counter[7:0];
        else if (idx == IDX_CNT1)     v = s.counter[15:8];
        else if (idx == IDX_CNT2)     v = s.counter[23:16];
        else if (idx == IDX_RLD0)     v = s.reload[7:0];
        else if (idx == IDX_RLD1)     v = s.reload[15:8];
        else if (idx == IDX_RLD2)     v = s.reload[23:16];
        else if (idx == IDX_STATUS)   v = s.status;
        else if (idx == IDX_CONTROL)  v = s.control;
        else if (idx == IDX_ACTIVATE) v = s.activate;
        else if (idx == IDX_BASE_HI)  v = s.base_hi;
        else if (idx == IDX_BASE_LO)  v = s.base_lo;
        else if (idx == IDX_IRQ)      v = s.irq_route;
        else if (idx == IDX_SPARE_F0) v = s.spare_f0;
        else if (idx == IDX_SRC_EN)   v = s.src_en;
        else if (idx == IDX_W1_LO)    v = s.win1_base[7:0];
        else if (idx == IDX_W1_HI)    v = s.win1_base[15:8];
        else if (idx == IDX_W2_LO)    v = s.win2_base[7:0];
        else if (idx == IDX_W2_HI)    v = s.win2_base[15:8];
        else if (idx == IDX_MASKS)    v = s.masks;
        return v;
    endfunction : reg_read

    // Address decode of the incoming cycle
    always_comb
    begin
        wr       = io_valid && io_write;
        rd       = io_valid && !io_write;
        cfg_hit  = s_r.cfg_mode && (io_addr == CFG_PORT_ADDR);                 // [RL3]
        data_hit = s_r.cfg_mode && (io_addr == DATA_PORT_ADDR);                // [RL3]
        dev_sel  = (s_r.logical_device_select == WDT_DEVICE_NUM);                                // [RL4]
        // Low three base bits are forced to zero, so the block is always aligned
        base_hit = s_r.activate[0]
                   && (io_addr[15:3] == {s_r.base_hi, s_r.base_lo[7:3]});     // [RL8] [RL9]
        // Mask bit set releases that address bit; 1 to 16 bytes per window
        win1_hit = s_r.activate[0] && (io_addr[15:4] == s_r.win1_base[15:4])
                   && (((io_addr[3:0] ^ s_r.win1_base[3:0]) & ~s_r.masks[7:4]) == 4'h0); // [RL18]
        win2_hit = s_r.activate[0] && (io_addr[15:4] == s_r.win2_base[15:4])
                   && (((io_addr[3:0] ^ s_r.win2_base[3:0]) & ~s_r.masks[3:0]) == 4'h0); // [RL19]
        // Data port reaches device registers only for the watchdog selector
        acc_en   = 1'b0;
        acc_we   = 1'b0;
        acc_idx  = 8'h00;
        if (data_hit)
        begin
            acc_en  = 1'b1;
            acc_we  = wr;
            acc_idx = s_r.index;
            if (!dev_sel && (s_r.index != IDX_LDN))
            begin
                acc_en = 1'b0;
            end
        end
        else if (base_hit && !cfg_hit)
        begin
            acc_en  = 1'b1;
            acc_we  = wr;
            acc_idx = IDX_CNT0 + {5'h00, io_addr[2:0]};                        // [RL5]
        end
        acc_rd   = (acc_idx == IDX_LDN) ? s_r.logical_device_select : reg_read(s_r, acc_idx);
    end

    // Reload triggers: counter write, port 80h write, window hits
    always_comb
    begin
        trigger = 1'b0;
        if (io_valid && acc_en && acc_we
            && (acc_idx >= IDX_CNT0) && (acc_idx <= IDX_CNT2))
        begin
            trigger = 1'b1;                                                    // [RL5] [RL16]
        end
        if (wr && s_r.activate[0] && (io_addr == POST_PORT_ADDR)
            && s_r.src_en[POS_POST])
        begin
            trigger = 1'b1;                                                    // [RL12]
        end
        if (wr && ((win1_hit && s_r.src_en[POS_W1_WR]) || (win2_hit && s_r.src_en[POS_W2_WR])))
        begin
            trigger = 1'b1;                                                    // [RL13]
        end
        if (rd && ((win1_hit && s_r.src_en[POS_W1_RD]) || (win2_hit && s_r.src_en[POS_W2_RD])))
        begin
            trigger = 1'b1;                                                    // [RL17]
        end
    end

    // Next-state logic for the whole block
    always_comb
    begin
        s_nxt              = s_r;
        s_nxt.rvalid       = 1'b0;
        s_nxt.reload_pulse = 1'b0;
        s_nxt.irq_lines    = 16'h0000;
        s_nxt.smi          = 1'b0;
        // Key tracking on every config-port write; index also loads in cfg mode
        if (wr && (io_addr == CFG_PORT_ADDR))
        begin
            if (s_r.cfg_mode)
            begin
                s_nxt.index = io_wdata;                                        // [RL3]
            end
            if (!s_r.cfg_mode && (s_r.key == KEY_GOT_ENTER) && (io_wdata == KEY_B))
            begin
                s_nxt.cfg_mode = 1'b1;                                         // [RL1]
                s_nxt.key      = KEY_IDLE;
            end
            else if (s_r.cfg_mode && (s_r.key == KEY_GOT_EXIT) && (io_wdata == KEY_A))
            begin
                s_nxt.cfg_mode = 1'b0;                                         // [RL2]
                s_nxt.key      = KEY_IDLE;
            end
            else if (!s_r.cfg_mode && (io_wdata == KEY_A))
            begin
                s_nxt.key = KEY_GOT_ENTER;                                     // [RL1]
            end
            else if (s_r.cfg_mode && (io_wdata == KEY_B))
            begin
                s_nxt.key = KEY_GOT_EXIT;                                      // [RL2]
            end
            else
            begin
                s_nxt.key = KEY_IDLE;                                          // [RL20]
            end
        end
        // Reads: index port in cfg mode, data port and base block
        if (rd && cfg_hit)
        begin
            s_nxt.rdata  = s_r.index;                                          // [RL3]
            s_nxt.rvalid = 1'b1;
        end
        else if (rd && acc_en)
        begin
            s_nxt.rdata  = acc_rd;
            s_nxt.rvalid = 1'b1;
        end
        // Register writes; counter bytes are reload triggers, not stores
        if (wr && acc_en)
        begin
            if (acc_idx == IDX_LDN)           s_nxt.logical_device_select = io_wdata;            // [RL4]
            else if (acc_idx == IDX_ACTIVATE) s_nxt.activate = {7'h00, io_wdata[0]}; // [RL9]
            else if (acc_idx == IDX_RLD0)     s_nxt.reload[7:0] = io_wdata;    // [RL6]
            else if (acc_idx == IDX_RLD1)     s_nxt.reload[15:8] = io_wdata;   // [RL6]
            else if (acc_idx == IDX_RLD2)     s_nxt.reload[23:16] = io_wdata;  // [RL6]
            else if (acc_idx == IDX_STATUS)   s_nxt.status = io_wdata;         // [RL7]
            else if (acc_idx == IDX_CONTROL)  s_nxt.control = io_wdata;        // [RL7]
            else if (acc_idx == IDX_BASE_HI)  s_nxt.base_hi = io_wdata;        // [RL8]
            else if (acc_idx == IDX_BASE_LO)  s_nxt.base_lo = {io_wdata[7:3], 3'b000}; // [RL8]
            else if (acc_idx == IDX_IRQ)      s_nxt.irq_route = {4'h0, io_wdata[3:0]}; // [RL10]
            else if (acc_idx == IDX_SPARE_F0) s_nxt.spare_f0 = io_wdata;
            else if (acc_idx == IDX_SRC_EN)   s_nxt.src_en = {3'h0, io_wdata[4:0]}; // [RL12][RL13]
            else if (acc_idx == IDX_W1_LO)    s_nxt.win1_base[7:0] = io_wdata; // [RL14]
            else if (acc_idx == IDX_W1_HI)    s_nxt.win1_base[15:8] = io_wdata;// [RL14]
            else if (acc_idx == IDX_W2_LO)    s_nxt.win2_base[7:0] = io_wdata; // [RL14]
            else if (acc_idx == IDX_W2_HI)    s_nxt.win2_base[15:8] = io_wdata;// [RL14]
            else if (acc_idx == IDX_MASKS)    s_nxt.masks = io_wdata;          // [RL15]
        end
        // A reload uses the value held before this cycle's own reload write
        if (trigger)
        begin
            s_nxt.counter      = s_r.reload;                                   // [RL16]
            s_nxt.reload_pulse = 1'b1;
        end
        // Timeout routing; 08h and 0dh-0fh are silent codes
        if (timeout_evt)
        begin
            if (s_r.irq_route[3:0] == ROUTE_SMI)
            begin
                s_nxt.smi = 1'b1;                                              // [RL10]
            end
            else if ((s_r.irq_route[3:0] != 4'h0) && (s_r.irq_route[3:0] != 4'h8)
                     && (s_r.irq_route[3:0] < 4'hd))
            begin
                s_nxt.irq_lines[s_r.irq_route[3:0]] = 1'b1;                    // [RL10] [RL11]
            end
        end
        if (!clk_en)
        begin
            s_nxt = s_r;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_r           <= '0;
            s_r.key       <= KEY_IDLE;
            s_r.logical_device_select       <= RST_LDN;                                          // [RL4]
            s_r.reload    <= RST_RELOAD;                                       // [RL6]
            s_r.status    <= RST_STATUS;                                       // [RL7]
            s_r.control   <= RST_CONTROL;                                      // [RL7]
            s_r.masks     <= RST_MASKS;                                        // [RL15]
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign io_rdata        = s_r.rdata;
    assign io_rvalid       = s_r.rvalid;
    assign counter_value   = s_r.counter;
    assign reload_value    = s_r.reload;
    assign timeout_control = s_r.control;
    assign timeout_status  = s_r.status;
    assign reload_pulse    = s_r.reload_pulse;
    assign device_active   = s_r.activate[0];
    assign irq_lines       = s_r.irq_lines;
    assign smi_out         = s_r.smi;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_enter_key: assert property (clk_en && wr && io_addr == CFG_PORT_ADDR && io_wdata == KEY_A
        && !s_r.cfg_mode ##1 clk_en && wr && io_addr == CFG_PORT_ADDR && io_wdata == KEY_B
        |=> s_r.cfg_mode) else $error("enter key not taken"); // [RL1]
    a_exit_key: assert property (clk_en && wr && io_addr == CFG_PORT_ADDR && io_wdata == KEY_B
        && s_r.cfg_mode ##1 clk_en && wr && io_addr == CFG_PORT_ADDR && io_wdata == KEY_A
        |=> !s_r.cfg_mode) else $error("exit key not taken"); // [RL2]
    a_ports_closed: assert property (!s_r.cfg_mode && rd && !base_hit
        |=> !io_rvalid) else $error("answered outside configuration"); // [RL3]
    a_reset_values: assert property (!$past(rst_n) |-> s_r.logical_device_select == RST_LDN
        && reload_value == RST_RELOAD && timeout_control == RST_CONTROL
        && s_r.masks == RST_MASKS) else $error("bad reset value"); // [RL4]
    a_reload_load: assert property (reload_pulse |-> counter_value == $past(reload_value))
        else $error("reload did not load counter"); // [RL16]
    a_post_reload: assert property (clk_en && wr && io_addr == POST_PORT_ADDR
        && s_r.src_en[POS_POST] && device_active |=> reload_pulse)
        else $error("port 80h reload missed"); // [RL12]
    a_window_read: assert property (clk_en && rd && win1_hit && s_r.src_en[POS_W1_RD]
        |=> reload_pulse) else $error("window read reload missed"); // [RL17]
    a_silent_codes: assert property (clk_en && timeout_evt && (s_r.irq_route[3:0] == 4'h8
        || s_r.irq_route[3:0] >= 4'hd) |=> irq_lines == 16'h0000 && !smi_out)
        else $error("silent route drove a line"); // [RL11]
    a_smi_route: assert property (clk_en && timeout_evt && s_r.irq_route[3:0] == ROUTE_SMI
        |=> smi_out && irq_lines == 16'h0000) else $error("smi route failed"); // [RL10]
    a_inactive_base: assert property (!device_active && !s_r.cfg_mode && rd
        |=> !io_rvalid) else $error("inactive device answered"); // [RL9]
    a_status_back: assert property (clk_en && wr && data_hit && dev_sel
        && s_r.index == IDX_STATUS |=> timeout_status == $past(io_wdata))
        else $error("status write-back lost"); // [RL7]

    c_enter: cover property (!s_r.cfg_mode ##1 s_r.cfg_mode);
    c_exit: cover property (s_r.cfg_mode ##1 !s_r.cfg_mode);
    c_window: cover property (win2_hit && io_valid ##1 reload_pulse);
    c_irq: cover property (irq_lines != 16'h0000);
endmodule : wdpc_config_port

// ---- wdpc_host_model.sv ----
// Purpose: Host-side model issuing decoded I/O cycles and timeout pulses
// Assumes: Cycles start and end on falling clock edges
// Notes:   Released address and data show the inverse of the last value
module wdpc_host_model
    import wdpc_pkg::*;
(
    input  wire logic        clk_sys,     // System clock
    output logic             io_valid,    // Cycle strobe
    output logic             io_write,    // 1 write, 0 read
    output logic      [15:0] io_addr,     // I/O address
    output logic      [7:0]  io_wdata,    // Write data
    output logic             timeout_evt, // Expiry pulse
    input  wire logic [7:0]  io_rdata,    // Read data
    input  wire logic        io_rvalid    // Read answered
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial
    begin
        io_valid    = 1'b0;
        io_write    = 1'b0;
        io_addr     = 16'h0000;
        io_wdata    = 8'h00;
        timeout_evt = 1'b0;
    end

    // One strobe cycle; index and data bytes go out this way
    task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] dat);
        @(negedge clk_sys);
        io_valid = 1'b1;
        io_write = wr;
        io_addr  = a;
        io_wdata = dat;
        @(negedge clk_sys);
        io_valid = 1'b0;
        io_addr  = ~a;   // Released lines never show a stale value
        io_wdata = ~dat;
    endtask : cyc

    // Two back-to-back writes to one port; strobe stays up between them
    task automatic cyc2(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
        @(negedge clk_sys);
        io_valid = 1'b1;
        io_write = 1'b1;
        io_addr  = a;
        io_wdata = d0;
        @(negedge clk_sys);
        io_wdata = d1;
        @(negedge clk_sys);
        io_valid = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d1;
    endtask : cyc2

    // Answer stands exactly in the cycle after the taking edge
    task automatic rd(input logic [15:0] a, output logic [7:0] dat, output bit got);
        cyc(1'b0, a, 8'h00);
        got = (io_rvalid === 1'b1);
        dat = io_rdata;
    endtask : rd

    // Expiry pulse of one cycle from the countdown engine
    task automatic evt();
        @(negedge clk_sys);
        timeout_evt = 1'b1;
        @(negedge clk_sys);
        timeout_evt = 1'b0;
    endtask : evt
endmodule : wdpc_host_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the configuration front end
// Assumes: Host model drives all I/O cycles at falling edges
// Notes:   Pulses are collected by a monitor, so no pulse is missed
module tb_top;
    import wdpc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys, rst_n, clk_en, io_valid, io_write, timeout_evt;
    logic [15:0] io_addr, irq_lines, irq_seen;
    logic [7:0]  io_wdata, io_rdata, d, tc, ts;
    logic [23:0] counter_value, reload_value;
    logic        io_rvalid, reload_pulse, device_active, smi_out, smi_seen;
    bit          g;
    int          num_errors, checks_done, n_rld;
    logic [7:0]  rst_idx [0:12] = '{8'h07, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h70,
                                    8'hf0, 8'hf1, 8'hf2, 8'hf5, 8'hf6, 8'h30};
    logic [7:0]  rst_exp [0:12] = '{8'h01, 8'h00, 8'h40, 8'h00, 8'h00, 8'h03, 8'h00,
                                    8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [7:0]  wr_idx [0:7] = '{8'h30, 8'h61, 8'h70, 8'hf1, 8'hf0, 8'hf3, 8'hf6, 8'h3e};
    logic [7:0]  wr_val [0:7] = '{8'hff, 8'hf8, 8'h5a, 8'hff, 8'h5a, 8'ha5, 8'hc3, 8'h5a};
    logic [7:0]  wr_exp [0:7] = '{8'h01, 8'hf8, 8'h0a, 8'h1f, 8'h5a, 8'ha5, 8'hc3, 8'h5a};

    wdpc_config_port i_wdpc_config_port (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .io_valid(io_valid), .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .timeout_evt(timeout_evt), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .counter_value(counter_value), .reload_value(reload_value), .timeout_control(tc),
        .timeout_status(ts), .reload_pulse(reload_pulse), .device_active(device_active),
        .irq_lines(irq_lines), .smi_out(smi_out));
    wdpc_host_model i_wdpc_host_model (.clk_sys(clk_sys), .io_valid(io_valid),
        .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .timeout_evt(timeout_evt), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

    // 200 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Pulse monitor; one-cycle pulses are easy to miss from the sequence
    always @(posedge clk_sys)
    begin
        if (reload_pulse === 1'b1)
            n_rld++;
        irq_seen |= irq_lines;
        smi_seen |= smi_out;
    end

    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok)
        begin
            num_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic key(input logic [7:0] a, input logic [7:0] b);
        i_wdpc_host_model.cyc2(CFG_PORT_ADDR, a, b);
    endtask : key

    task automatic cw(input logic [7:0] idx, input logic [7:0] v);
        i_wdpc_host_model.cyc(1'b1, CFG_PORT_ADDR, idx);
        i_wdpc_host_model.cyc(1'b1, DATA_PORT_ADDR, v);
    endtask : cw

    task automatic cr(input logic [7:0] idx, input logic [7:0] e);
        i_wdpc_host_model.cyc(1'b1, CFG_PORT_ADDR, idx);
        i_wdpc_host_model.rd(DATA_PORT_ADDR, d, g);
        chk(g && d === e, "config read mismatch");
    endtask : cr

    // Counts reload pulses caused by one cycle
    task automatic trig(input logic wr, input logic [15:0] a, input int e);
        int n0;
        n0 = n_rld;
        i_wdpc_host_model.cyc(wr, a, 8'h77);
        @(negedge clk_sys);
        chk(n_rld - n0 == e, "reload pulse count wrong");
    endtask : trig

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // Hang guard
    initial
    begin
        #200000;
        num_errors++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        i_wdpc_host_model.rd(CFG_PORT_ADDR, d, g);
        chk(!g, "index port answered outside mode");
        key(KEY_A, 8'h00);
        i_wdpc_host_model.rd(DATA_PORT_ADDR, d, g);
        chk(!g, "broken key opened mode");
        key(KEY_A, KEY_B);
        for (int i = 0; i < 13; i++)
            cr(rst_idx[i], rst_exp[i]);
        chk(tc === RST_CONTROL && ts === RST_STATUS && reload_value === RST_RELOAD
            && device_active === 1'b0, "reset outputs wrong");
        for (int i = 0; i < 8; i++)
        begin
            cw(wr_idx[i], wr_val[i]);
            cr(wr_idx[i], wr_exp[i]);
        end
        chk(ts === 8'h5a && device_active === 1'b1, "status or activate output wrong");
        // A write while frozen must be lost
        clk_en = 1'b0;
        cw(IDX_CONTROL, 8'h00);
        clk_en = 1'b1;
        cr(IDX_CONTROL, RST_CONTROL);
        $display("test registers done");
        cw(8'h3b, 8'h12);
        cw(8'h3c, 8'h34);
        cw(8'h3d, 8'h56);
        i_wdpc_host_model.cyc(1'b1, CFG_PORT_ADDR, IDX_CNT0);
        trig(1'b1, DATA_PORT_ADDR, 1);
        chk(counter_value === 24'h563412, "counter not reloaded");
        chk(reload_value === 24'h563412, "reload output wrong");
        cr(8'h3a, 8'h56);
        cw(8'h60, 8'h12);
        cw(8'h61, 8'h38);
        i_wdpc_host_model.rd(16'h123c, d, g);
        chk(g && d === 8'h34, "base block read wrong");
        trig(1'b1, 16'h1239, 1);
        cw(8'h07, 8'h02);
        i_wdpc_host_model.cyc(1'b1, CFG_PORT_ADDR, IDX_STATUS);
        i_wdpc_host_model.rd(DATA_PORT_ADDR, d, g);
        chk(!g, "other device answered");
        cw(8'h07, WDT_DEVICE_NUM);
        $display("test counter done");
        cw(8'hf1, 8'h00);
        trig(1'b1, POST_PORT_ADDR, 0);
        cw(8'hf1, 8'h10);
        trig(1'b1, POST_PORT_ADDR, 1);
        cw(8'hf2, 8'h00);
        cw(8'hf3, 8'h04);
        cw(8'hf4, 8'h00);
        cw(8'hf5, 8'h05);
        cw(8'hf6, 8'h30);
        cw(8'hf1, 8'h02);
        trig(1'b1, 16'h0403, 1);
        trig(1'b1, 16'h0404, 0);
        trig(1'b0, 16'h0401, 0);
        cw(8'hf1, 8'h01);
        trig(1'b0, 16'h0401, 1);
        trig(1'b1, 16'h0401, 0);
        cw(8'hf1, 8'h08);
        trig(1'b1, 16'h0500, 1);
        trig(1'b1, 16'h0501, 0);
        cw(8'hf1, 8'h04);
        trig(1'b0, 16'h0500, 1);
        $display("test reload done");
        for (int c = 0; c < 16; c++)
        begin
            cw(IDX_IRQ, 8'(c));
            irq_seen = 16'h0000;
            smi_seen = 1'b0;
            i_wdpc_host_model.evt();
            @(negedge clk_sys);
            g = (c == 1) || (c >= 3 && c <= 7) || (c >= 9 && c <= 12);
            chk(irq_seen === (g ? 16'h0001 << c : 16'h0000), "irq route");
            chk(smi_seen === (c == 2), "smi route");
        end
        $display("test routing done");
        key(KEY_B, KEY_A);
        i_wdpc_host_model.rd(DATA_PORT_ADDR, d, g);
        chk(!g, "data port open after exit");
        $display("test exit done");
        complete_run();
    end
endmodule : tb_top
